//--- shared/stc_pkg.sv
/*
 * Constants, register map and carrier types of the system time control loop.
 * Assumes a byte-wide register access from the network side and the local host side.
 */
package stc_pkg;
    localparam logic [11:0] STC_OFFSET_ADDR = 12'h920;
    localparam logic [11:0] STC_DELAY_ADDR  = 12'h928;
    localparam logic [11:0] STC_DIFF_ADDR   = 12'h92C;
    localparam logic [11:0] STC_START_ADDR  = 12'h930;
    localparam logic [11:0] STC_SDIFF_ADDR  = 12'h932;
    localparam logic [11:0] STC_DFILT_ADDR  = 12'h934;
    localparam logic [11:0] STC_SFILT_ADDR  = 12'h935;
    localparam int          STC_MAP_BYTES   = 22;
    // byte indices inside the map image
    localparam int          STC_IDX_DELAY   = 8;
    localparam int          STC_IDX_START   = 16;
    localparam int          STC_IDX_DFILT   = 20;
    localparam int          STC_IDX_SFILT   = 21;

    localparam logic [63:0] STC_OFFSET_RST  = 64'h0;
    localparam logic [31:0] STC_DELAY_RST   = 32'h0;
    localparam logic [14:0] STC_START_RST   = 15'h1000;
    localparam logic [3:0]  STC_DFILT_RST   = 4'h4;
    localparam logic [3:0]  STC_SFILT_RST   = 4'hC;
    localparam logic [15:0] STC_SPEED_FLOOR = 16'h007F;

    localparam int          STC_CLK_PERIOD_NS = 4;
    localparam logic [63:0] STC_STEP_NS     = 64'(STC_CLK_PERIOD_NS);

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } stc_acc_t;

    typedef struct packed {
        logic        sof;
        logic        cmp;
        logic [31:0] rx_time;
    } stc_frame_t;
endpackage : stc_pkg

//--- verilog/stc_avg.sv
/*
 * Exponential averaging filter: mean moves by (sample - mean) / 2^depth per sample.
 * Assumes load and clear are single-cycle strobes on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module stc_avg (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    input  wire logic               clr_i,
    input  wire logic               load_i,
    input  wire logic signed [31:0] sample_i,
    input  wire logic        [3:0]  depth_i,
    output logic signed      [31:0] mean_o
);
    logic signed [31:0] mean_reg;
    logic signed [31:0] mean_next;
    logic signed [32:0] delta;

    always_comb begin
        delta     = 33'(sample_i) - 33'(mean_reg);
        mean_next = mean_reg;
        if (clr_i) begin
            mean_next = '0;
        end else if (load_i) begin
            mean_next = 32'(33'(mean_reg) + (delta >>> depth_i));
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mean_reg <= '0;
        end else if (ce_i) begin
            mean_reg <= mean_next;
        end
    end

    assign mean_o = mean_reg;
endmodule : stc_avg
`default_nettype wire

//--- verilog/stc_loop.sv
/*
 * System time control loop: offset, delay, filtered difference, speed counter
 * and filter depth registers, with the local copy of system time.
 * Assumes both register ports and frame strobes come from logic on sys_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (R1) System time copy is free-running local time plus the 64-bit offset; the code also adds the speed counter correction adj_reg.
// (R2) A 32-bit propagation delay is added to the copy latched at frame start.
// (R3) Controller should write speed start after changing the delay.
// (R4) Bits 30:0 of the difference register show filtered mean magnitude.
// (R5) Bit 31 is set when the local copy is below the received time.
// (R6) 15-bit speed start sets loop bandwidth; bit 15 reads zero.
// (R7) Software keeps speed start between 0x0080 and 0x3FFF.
// (R8) Writing speed start clears the difference and period deviation values.
// (R9) Period deviation is 16-bit two's complement, limited to start minus 0x7F.
// (R10) Difference filter depth is 4 bits; a write clears the difference.
// (R11) Speed filter depth is 4 bits; a write resets the speed filter.
// (R12) Network side may write; host side writes only under host control.
// (R13) Software derives clock deviation from start and deviation once settled.
// (R14) Received system time is compared at frame end with the latched copy.
// (R15) Reserved filter depth bits read zero and ignore writes.
module stc_loop (
    input  wire logic                sys_clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic                host_ctrl_i,
    input  wire stc_pkg::stc_acc_t   net_acc_i,
    input  wire stc_pkg::stc_acc_t   host_acc_i,
    input  wire stc_pkg::stc_frame_t frame_i,
    output logic [7:0]               net_rdata_o,
    output logic [7:0]               host_rdata_o,
    output logic [63:0]              sys_time_o
);
    import stc_pkg::*;

    logic [63:0]        offset_reg, offset_next;
    logic [31:0]        delay_reg, delay_next;
    logic [14:0]        start_reg, start_next;
    logic [3:0]         dfilt_reg, dfilt_next;
    logic [3:0]         sfilt_reg, sfilt_next;
    logic [63:0]        local_reg, local_next;
    logic [63:0]        adj_reg, adj_next;
    logic [63:0]        sys_reg, sys_next;
    logic [63:0]        latch_reg, latch_next;
    logic signed [15:0] speed_reg, speed_next;
    logic [15:0]        cnt_reg, cnt_next;
    logic [7:0]         nrd_reg, nrd_next;
    logic [7:0]         hrd_reg, hrd_next;

    stc_acc_t            wacc;
    logic                wen;
    logic [11:0]         widx;
    logic                start_wr, dfilt_wr, sfilt_wr;
    logic signed [31:0]  diff_raw, diff_mean, dev_mean;
    logic [31:0]         diff_reg_val;
    logic signed [15:0]  dev_val, limit;
    logic [15:0]         dev_mag;
    logic [8*STC_MAP_BYTES-1:0] image;

    function automatic logic [7:0] map_byte(input logic [11:0] a,
                                            input logic [8*STC_MAP_BYTES-1:0] img);
        logic [11:0] i;
        i = a - STC_OFFSET_ADDR;
        if (a >= STC_OFFSET_ADDR && i < 12'(STC_MAP_BYTES)) begin
            map_byte = img[8*i+:8];
        end else begin
            map_byte = 8'h00;
        end
    endfunction : map_byte

    stc_avg u_diff_avg (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .clr_i     (start_wr | dfilt_wr),                     // [R8] [R10]
        .load_i    (frame_i.cmp),
        .sample_i  (diff_raw),
        .depth_i   (dfilt_reg),
        .mean_o    (diff_mean)
    );

    stc_avg u_speed_avg (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .clr_i     (start_wr | sfilt_wr),                     // [R8] [R11]
        .load_i    (frame_i.cmp),
        .sample_i  (32'(speed_reg)),
        .depth_i   (sfilt_reg),
        .mean_o    (dev_mean)
    );

    always_comb begin
        // network write has priority; host write only under host control
        wen  = net_acc_i.wr | (host_acc_i.wr & host_ctrl_i);        // [R12]
        wacc = net_acc_i.wr ? net_acc_i : host_acc_i;
        widx = wacc.addr - STC_OFFSET_ADDR;
        if (wacc.addr < STC_OFFSET_ADDR || widx >= 12'(STC_MAP_BYTES)) begin
            wen = 1'b0;
        end
        start_wr = wen && (widx == 12'(STC_IDX_START) || widx == 12'(STC_IDX_START + 1));
        dfilt_wr = wen && widx == 12'(STC_IDX_DFILT);
        sfilt_wr = wen && widx == 12'(STC_IDX_SFILT);

        offset_next = offset_reg;
        delay_next  = delay_reg;
        start_next  = start_reg;
        dfilt_next  = dfilt_reg;
        sfilt_next  = sfilt_reg;
        if (wen) begin
            for (int b = 0; b < 8; b++) begin
                if (widx == 12'(b)) offset_next[8*b+:8] = wacc.wdata;
            end
            for (int b = 0; b < 4; b++) begin
                if (widx == 12'(STC_IDX_DELAY + b)) delay_next[8*b+:8] = wacc.wdata;
            end
            if (widx == 12'(STC_IDX_START)) start_next[7:0] = wacc.wdata;
            if (widx == 12'(STC_IDX_START + 1)) start_next[14:8] = wacc.wdata[6:0]; // [R6]
            if (dfilt_wr) dfilt_next = wacc.wdata[3:0];                          // [R15]
            if (sfilt_wr) sfilt_next = wacc.wdata[3:0];                          // [R15]
        end
    end

    always_comb begin
        diff_raw = $signed(latch_reg[31:0] - frame_i.rx_time);                 // [R14]
        limit    = $signed({1'b0, start_reg}) - $signed(STC_SPEED_FLOOR);
        dev_val  = 16'(dev_mean);
        dev_mag  = dev_val[15] ? 16'(-dev_val) : 16'(dev_val);
        diff_reg_val[31]   = diff_mean[31];                                   // [R5]
        diff_reg_val[30:0] = diff_mean[31] ? 31'(-diff_mean) : diff_mean[30:0]; // [R4]

        image = {4'h0, sfilt_reg, 4'h0, dfilt_reg, dev_val, 1'b0, start_reg,
                 diff_reg_val, delay_reg, offset_reg};                         // [R9] [R15]

        speed_next = speed_reg;
        if (start_wr) begin
            speed_next = '0;                                                   // [R8]
        end else if (frame_i.cmp) begin
            if (diff_raw < 0 && speed_reg < limit) begin
                speed_next = speed_reg + 16'sd1;                               // [R9]
            end else if (diff_raw > 0 && speed_reg > -limit) begin
                speed_next = speed_reg - 16'sd1;                               // [R9]
            end
        end

        // speed counter: a one-nanosecond correction, signed as the deviation, each time it runs out with nonzero deviation
        cnt_next = cnt_reg - 16'h0001;
        adj_next = adj_reg;
        if (cnt_reg == 16'h0000) begin
            cnt_next = {1'b0, start_reg} - dev_mag;                            // [R6]
            if (dev_val > 0) adj_next = adj_reg + 64'h1;
            else if (dev_val < 0) adj_next = adj_reg - 64'h1;
        end
        if (wen && widx < 12'(STC_IDX_DELAY)) begin
            adj_next = '0;
        end

        local_next = local_reg + STC_STEP_NS;
        sys_next   = local_reg + offset_reg + adj_reg;                         // [R1]
        latch_next = frame_i.sof ? sys_reg + {32'h0, delay_reg} : latch_reg;   // [R2]
        nrd_next   = net_acc_i.rd ? map_byte(net_acc_i.addr, image) : nrd_reg;
        hrd_next   = host_acc_i.rd ? map_byte(host_acc_i.addr, image) : hrd_reg;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            offset_reg <= STC_OFFSET_RST;
            delay_reg  <= STC_DELAY_RST;
            start_reg  <= STC_START_RST;
            dfilt_reg  <= STC_DFILT_RST;
            sfilt_reg  <= STC_SFILT_RST;
            local_reg  <= '0;
            adj_reg    <= '0;
            sys_reg    <= '0;
            latch_reg  <= '0;
            speed_reg  <= '0;
            cnt_reg    <= '0;
            nrd_reg    <= '0;
            hrd_reg    <= '0;
        end else if (ce_i) begin
            offset_reg <= offset_next;
            delay_reg  <= delay_next;
            start_reg  <= start_next;
            dfilt_reg  <= dfilt_next;
            sfilt_reg  <= sfilt_next;
            local_reg  <= local_next;
            adj_reg    <= adj_next;
            sys_reg    <= sys_next;
            latch_reg  <= latch_next;
            speed_reg  <= speed_next;
            cnt_reg    <= cnt_next;
            nrd_reg    <= nrd_next;
            hrd_reg    <= hrd_next;
        end
    end

    assign net_rdata_o  = nrd_reg;
    assign host_rdata_o = hrd_reg;
    assign sys_time_o   = sys_reg;

    host_block_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R12]
        ce_i && !net_acc_i.wr && host_acc_i.wr && !host_ctrl_i
        |=> $stable(delay_reg) && $stable(start_reg) && $stable(offset_reg))
        else $error("host write taken without host control");
    start_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R8]
        ce_i && start_wr |=> diff_mean == 0 && dev_mean == 0 && speed_reg == 0)
        else $error("speed start write did not clear difference values");
    dfilt_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R10]
        ce_i && dfilt_wr |=> diff_mean == 0 && dfilt_reg == $past(wacc.wdata[3:0]))
        else $error("difference depth write did not clear mean");
    sfilt_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R11]
        ce_i && sfilt_wr |=> dev_mean == 0)
        else $error("speed depth write did not reset speed filter");
    diff_sign_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R5]
        ce_i && frame_i.cmp && dfilt_reg == 4'h0 && !start_wr && !dfilt_wr
        |=> diff_reg_val[31] == $past($signed(latch_reg[31:0] - frame_i.rx_time) < 0))
        else $error("difference sign bit wrong");
    speed_limit_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R9]
        speed_reg <= limit && speed_reg >= -limit || $changed(start_reg))
        else $error("speed value outside limit");
    sys_sum_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R1]
        ce_i ##1 ce_i |=> sys_reg == $past(local_reg) + $past(offset_reg) + $past(adj_reg))
        else $error("system time copy is not local time plus offset");
    sof_latch_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R2]
        ce_i && frame_i.sof |=> latch_reg == $past(sys_reg) + {32'h0, $past(delay_reg)})
        else $error("frame start latch lacks delay");
    depth_rsvd_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R15]
        ce_i && net_acc_i.rd && net_acc_i.addr == STC_DFILT_ADDR |=> net_rdata_o[7:4] == 4'h0)
        else $error("reserved depth bits read nonzero");
    freeze_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !ce_i |=> $stable(sys_reg) && $stable(local_reg))
        else $error("state moved with clock enable low");

    cmp_cov: cover property (@(posedge sys_clk_i) disable iff (rst_i) ce_i && frame_i.cmp);
    start_cov: cover property (@(posedge sys_clk_i) disable iff (rst_i) ce_i && start_wr);
    host_cov: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && host_acc_i.wr && host_ctrl_i && !net_acc_i.wr);
endmodule : stc_loop
`default_nettype wire

//--- sim/stc_master.sv
/*
 * Frame source model: a start-of-frame strobe, then an end-of-frame compare.
 * Assumes go_i is a one-cycle pulse and rx_i is held until done_o.
 */
`timescale 1ns/1ps
`default_nettype none
module stc_master (
    input  wire logic           sys_clk_i,
    input  wire logic           rst_i,
    input  wire logic           go_i,
    input  wire logic [31:0]    rx_i,
    output var stc_pkg::stc_frame_t frame_o,
    output logic                done_o
);
    import stc_pkg::*;
    logic [2:0] cnt_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            frame_o <= '0;
            done_o  <= 1'b0;
        end else begin
            // start of frame always precedes the compare
            frame_o.sof <= go_i;
            frame_o.cmp <= (cnt_reg == 3'd1);
            done_o      <= (cnt_reg == 3'd1);
            // received time is only valid with the compare strobe
            frame_o.rx_time <= (cnt_reg == 3'd1) ? rx_i : ~frame_o.rx_time;
            cnt_reg <= go_i ? 3'd4 : ((cnt_reg != 3'd0) ? cnt_reg - 3'd1 : 3'd0);
        end
    end
endmodule : stc_master
`default_nettype wire

//--- sim/tb_top.sv
/*
 * Self-checking bench of the system time control loop.
 * Assumes stc_master drives the frame strobes on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import stc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        ce      = 1'b1;
    logic        hc      = 1'b0;
    logic        go      = 1'b0;
    logic [31:0] rx      = '0;
    stc_acc_t    net     = '0;
    stc_acc_t    host    = '0;
    stc_frame_t  frm;
    logic [7:0]  net_rd;
    logic [7:0]  host_rd;
    logic [63:0] st;
    logic        done;
    logic [31:0] dly     = '0;
    int          n_errors = 0;
    int          samples_checked = 0;

    always #2 sys_clk = ~sys_clk;

    stc_loop i_dut (.sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .host_ctrl_i(hc),
        .net_acc_i(net), .host_acc_i(host), .frame_i(frm), .net_rdata_o(net_rd),
        .host_rdata_o(host_rd), .sys_time_o(st));
    stc_master i_mst (.sys_clk_i(sys_clk), .rst_i(rst), .go_i(go), .rx_i(rx),
        .frame_o(frm), .done_o(done));

    task automatic stop_test;
        $display("compared %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk

    // magnitude of a 1000 ns difference, allowing a few cycles of latch skew
    task automatic chkr(input string n, input logic [63:0] g);
        samples_checked++;
        if ((g >= 64'd992 && g <= 64'd1008) !== 1'b1) begin
            n_errors++;
            $display("unexpected %s: expected 992..1008 seen %0d", n, g);
        end
    endtask : chkr

    // divisor of the clock deviation formula for a settled loop
    function automatic logic [63:0] dev_div(input logic [15:0] s, input logic [15:0] d);
        longint sv;
        longint dv;
        sv = longint'(s);
        dv = longint'($signed(d));
        dev_div = 64'(5 * (sv + dv + 2) * (sv - dv + 2));
    endfunction : dev_div

    task automatic wr(input logic h, input logic c, input logic [11:0] a,
                      input logic [7:0] d);
        @(posedge sys_clk);
        hc <= c;
        if (h) host <= '{1'b1, 1'b0, a, d};
        else net <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        net  <= '0;
        host <= '0;
    endtask : wr

    task automatic rd(input logic h, input logic [11:0] a, input int n,
                      output logic [63:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            if (h) host <= '{1'b0, 1'b1, a + 12'(i), 8'h00};
            else net <= '{1'b0, 1'b1, a + 12'(i), 8'h00};
            @(posedge sys_clk);
            net  <= '0;
            host <= '0;
            #1;
            v[8*i +: 8] = h ? host_rd : net_rd;
        end
    endtask : rd

    task automatic rdc(input string s, input logic h, input logic [11:0] a,
                       input int n, input logic [63:0] e);
        logic [63:0] r;
        rd(h, a, n, r);
        chk(s, e, r);
    endtask : rdc

    // received time = latched copy + d, so a positive d means local is behind
    task automatic frame(input logic signed [31:0] d);
        int i;
        @(posedge sys_clk);
        go <= 1'b1;
        rx <= st[31:0] + dly + 32'd8 + d;
        @(posedge sys_clk);
        go <= 1'b0;
        for (i = 0; i < 20 && done !== 1'b1; i++) @(posedge sys_clk);
        if (i == 20) begin
            n_errors++;
            stop_test();
        end
        repeat (2) @(posedge sys_clk);
    endtask : frame

    initial begin
        logic [63:0] v;
        logic [63:0] t0;
        logic        h;
        logic        c;
        logic [1:0]  a;
        logic [7:0]  b;
        void'($urandom(32'h26a7));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rdc("offset", 0, STC_OFFSET_ADDR, 8, 64'h0);
        rdc("delay", 0, STC_DELAY_ADDR, 4, 64'h0);
        rdc("diff", 0, STC_DIFF_ADDR, 4, 64'h0);
        rdc("start", 0, STC_START_ADDR, 2, 64'h1000);
        rdc("speed diff", 0, STC_SDIFF_ADDR, 2, 64'h0);
        rdc("depths", 1, STC_DFILT_ADDR, 2, 64'h0C04);
        rdc("unmapped", 0, 12'h936, 2, 64'h0);
        @(posedge sys_clk);
        #1;
        t0 = st;
        b = 8'($urandom);
        wr(0, 0, STC_OFFSET_ADDR, b);
        repeat (8) @(posedge sys_clk);
        #1;
        chk("time step", 64'd40 + 64'(b), st - t0);
        ce <= 1'b0;
        t0 = st;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("frozen", 64'h0, st - t0);
        ce <= 1'b1;
        v = {$urandom, $urandom};
        for (int i = 0; i < 8; i++) wr(0, 0, STC_OFFSET_ADDR + 12'(i), v[8*i +: 8]);
        rdc("offset", 1, STC_OFFSET_ADDR, 8, v);
        for (int k = 0; k < 12; k++) begin
            h = 1'($urandom);
            c = 1'($urandom);
            a = 2'($urandom);
            b = 8'($urandom);
            wr(h, c, STC_DELAY_ADDR + 12'(a), b);
            if (!h || c) dly[8*a +: 8] = b;
        end
        wr(1, 0, STC_DELAY_ADDR, ~dly[7:0]);
        wr(1, 1, STC_DELAY_ADDR + 12'd1, 8'h5A);
        dly[15:8] = 8'h5A;
        rdc("delay", 1, STC_DELAY_ADDR, 4, 64'(dly));
        wr(0, 0, STC_START_ADDR, 8'h80);
        wr(0, 0, STC_START_ADDR + 12'd1, 8'hFF);
        rdc("start high", 0, STC_START_ADDR + 12'd1, 1, 64'h7F);
        wr(0, 0, STC_START_ADDR + 12'd1, 8'h00);
        wr(0, 0, STC_DFILT_ADDR, 8'hFF);
        rdc("diff depth", 0, STC_DFILT_ADDR, 1, 64'h0F);
        wr(0, 0, STC_DFILT_ADDR, 8'h00);
        wr(0, 0, STC_SFILT_ADDR, 8'h00);
        repeat (3) frame(32'sd1000);
        rd(0, STC_DIFF_ADDR, 4, v);
        chk("diff sign", 64'h1, 64'(v[31]));
        chkr("diff size", 64'(v[30:0]));
        rdc("speed clamp", 0, STC_SDIFF_ADDR, 2, 64'h1);
        rd(0, STC_START_ADDR, 2, t0);
        rd(0, STC_SDIFF_ADDR, 2, v);
        chk("deviation divisor", 64'd84495, dev_div(t0[15:0], v[15:0]));
        wr(0, 0, STC_DIFF_ADDR + 12'd3, 8'h00);
        rd(0, STC_DIFF_ADDR + 12'd3, 1, v);
        chk("read-only diff", 64'h1, 64'(v[7]));
        wr(0, 0, STC_DFILT_ADDR, 8'h00);
        rdc("diff cleared", 0, STC_DIFF_ADDR, 4, 64'h0);
        rdc("speed kept", 0, STC_SDIFF_ADDR, 2, 64'h1);
        wr(0, 0, STC_SFILT_ADDR, 8'h00);
        rdc("speed reset", 0, STC_SDIFF_ADDR, 2, 64'h0);
        frame(32'sd1000);
        wr(0, 0, STC_START_ADDR, 8'h80);
        rdc("start clears diff", 0, STC_DIFF_ADDR, 4, 64'h0);
        rdc("start clears speed", 0, STC_SDIFF_ADDR, 2, 64'h0);
        // the deviation filter takes the speed value held before each compare
        repeat (2) frame(-32'sd1000);
        rd(0, STC_DIFF_ADDR, 4, v);
        chk("diff sign", 64'h0, 64'(v[31]));
        chkr("diff size", 64'(v[30:0]));
        rdc("speed negative", 0, STC_SDIFF_ADDR, 2, 64'hFFFF);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
